//--- logic/uart_lin_params.svh
`ifndef UART_LIN_PARAMS_SVH
`define UART_LIN_PARAMS_SVH
`define OVERSAMPLE 16
`define OVS_MID_A 7
`define OVS_MID_B 8
`define OVS_MID_C 9
`define LIN_BREAK_BITS 13
`define FIFO_DEPTH 4
`define BAUD_DIV_W 16
`define TX_FLAGS_RST 1'b1
`endif

//--- logic/uart_lin_pkg.sv
package uart_lin_pkg;
  typedef logic [8:0] word_t;
  typedef logic [15:0] div_t;
endpackage

//--- logic/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // async reset, active low
  input wire logic flush_i, // drop all content
  input wire logic [WIDTH-1:0] in_data_i, // write word
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // not full
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // not empty
  input wire logic out_ready_i // pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_nxt = flush_i ? '0 : wp_r + (AW+1)'(push);
    rp_nxt = flush_i ? '0 : rp_r + (AW+1)'(pop);
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end
  assign in_ready_o = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid_o = (wp_r != rp_r);
  assign out_data_o = mem_r[rp_r[AW-1:0]];
endmodule

//--- logic/baud_tick.sv
`timescale 1ns/1ps
module baud_tick #(
  parameter int DW = 16
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // async reset, active low
  input wire logic run_i, // counting allowed
  input wire logic [DW-1:0] div_i, // clocks per oversample tick
  output logic tick_o // one-cycle pulse
);
  logic [DW-1:0] cnt_r, cnt_nxt;
  logic tick_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    // divisors below 2 stop the generator
    if (!run_i || div_i < DW'(2)) begin
      cnt_nxt = '0;
    end else if (cnt_r >= div_i - DW'(1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + DW'(1);
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule

//--- logic/uart_lin.sv
`timescale 1ns/1ps
`include "uart_lin_params.svh"
// Summary of operation
// - output floats when transmitter off, idles high when nothing to send.
// - frame is start bit, 8 or 9 data bits lsb first, stop bit.
// - start bit drives low, stop bit drives high.
// - idle character is a full frame of ones.
// - 9-bit mode takes the top bit from the transmit ninth bit input.
// - break frames of all zeros repeat while send break is held.
// - one high bit follows the last break frame.
// - LIN master with 8-bit words sends a 13-bit break.
// - enabling transmitter sends one idle frame first.
// - toggling enable mid-frame queues an idle frame and drops buffered data.
// - data written during a frame waits in the holding buffer.
// - data written while idle starts at once and sets empty flag.
// - empty flag clears only on status access then data write.
// - empty flag requests interrupt when its enable and group unmask set.
// - done flag sets after a data frame's stop bit or after a break; interrupt when enabled.
// - the same sequence clears the done flag.
// - receiver puts the ninth received bit into the ninth bit field.
// - receiver enable starts hunting for a start bit.
// - completed character goes to holding buffer, sets full flag, interrupt.
// - receiver flags framing, noise and overrun errors.
// - transmit and receive have separate baud generators.
// - receiver oversamples each bit to reject noise.
// - full flag clears on status access then data read.
// - overrun keeps buffered word, shift register overwritten.
// - received break is a framing error.
// - noise flag is set only when a character sets the full flag.
module uart_lin
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic CLK_I, // 200 MHz clock
  input wire logic RSTN_I, // async reset, active low
  input wire logic SERIAL_IN_PIN_I, // receive data pin
  output logic SERIAL_OUT_O, // transmit data pin level
  output logic SERIAL_OUT_OE_O, // transmit pin drive enable
  input wire logic TX_ON_I, // transmitter enable
  input wire logic RX_ON_I, // receiver enable
  input wire logic WORD9_I, // 9-bit words when high
  input wire logic LIN_MASTER_I, // LIN master break length
  input wire logic SEND_BREAK_I, // send break frames
  input wire logic TX_NINTH_BIT_I, // ninth bit to send
  input wire uart_lin_pkg::div_t TX_DIV_I, // tx clocks per sixteenth bit
  input wire uart_lin_pkg::div_t RX_DIV_I, // rx clocks per sixteenth bit
  input wire logic TX_EMPTY_IRQ_EN_I, // empty flag irq enable
  input wire logic TX_DONE_IRQ_EN_I, // done flag irq enable
  input wire logic RX_FULL_IRQ_EN_I, // full flag irq enable
  input wire logic GROUP0_IRQ_UNMASK_I, // group irq unmask
  input wire logic STATUS_ACCESS_I, // status register access pulse
  input wire logic DATA_WR_I, // data port write pulse
  input wire logic [7:0] DATA_WDATA_I, // data port write value
  input wire logic DATA_RD_I, // data port read pulse
  output logic [7:0] DATA_RDATA_O, // receive holding buffer
  output logic RX_NINTH_BIT_O, // received ninth bit
  output logic TX_BUFFER_EMPTY_FLAG_O, // transmit buffer empty
  output logic TX_DONE_FLAG_O, // transmission complete
  output logic RX_BUFFER_FULL_FLAG_O, // receive buffer full
  output logic OVERRUN_FLAG_O, // overrun error
  output logic NOISE_FLAG_O, // noise error
  output logic FRAMING_FLAG_O, // framing error
  output logic IRQ_O // interrupt request
);
  import uart_lin_pkg::*;
  if (FIFO_DEPTH != `FIFO_DEPTH) begin : g_depth_chk
    $error("FIFO_DEPTH must be 4");
  end
  typedef enum logic [4:0] {
    TS_OFF = 5'h01, TS_IDLE = 5'h02, TS_START = 5'h04, TS_DATA = 5'h08, TS_STOP = 5'h10
  } tx_st_e;
  typedef enum logic [3:0] {
    RS_HUNT = 4'h1, RS_START = 4'h2, RS_DATA = 4'h4, RS_STOP = 4'h8
  } rx_st_e;
  // frame length in data bits for the current mode
  function automatic logic [3:0] data_bits(input logic w9);
    return w9 ? 4'h9 : 4'h8;
  endfunction
  // tx side
  logic tx_tick, rx_tick;
  tx_st_e ts_r, ts_nxt;
  logic [3:0] tph_r, tph_nxt;
  logic [3:0] tbit_r, tbit_nxt;
  word_t tsh_r, tsh_nxt;
  logic tkind_r, tkind_nxt; // 1: data frame, 0: idle or break
  logic tbrk_r, tbrk_nxt;
  logic tmark_r, tmark_nxt; // pending extra one after break
  logic tidle_r, tidle_nxt; // idle frame pending
  logic ton_d_r;
  logic sarm_r, sarm_nxt; // status access seen
  logic tde_r, tde_nxt, tc_r, tc_nxt;
  logic out_r, out_nxt, oe_r, oe_nxt;
  logic pend_ok, f_valid, f_pop;
  word_t f_data, wr_word;
  logic [4:0] brk_len;
  baud_tick #(.DW(`BAUD_DIV_W)) u_txb (
    .clk_i(CLK_I), .rstn_i(RSTN_I), .run_i(TX_ON_I || ts_r != TS_OFF),
    .div_i(TX_DIV_I), .tick_o(tx_tick));
  assign wr_word = {WORD9_I ? TX_NINTH_BIT_I : 1'b0, DATA_WDATA_I};
  logic f_push;
  // queue unless the idle path takes the word straight into the shifter, else it is lost
  assign f_push = DATA_WR_I && sarm_r && TX_ON_I
    && !(ts_r == TS_IDLE && !tidle_r && !tmark_r && !SEND_BREAK_I && !f_valid);
  word_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I), .rstn_i(RSTN_I), .flush_i(TX_ON_I && !ton_d_r),
    .in_data_i(wr_word), .in_valid_i(f_push), .in_ready_o(pend_ok),
    .out_data_o(f_data), .out_valid_o(f_valid), .out_ready_i(f_pop));
  assign brk_len = (LIN_MASTER_I && !WORD9_I) ? 5'(`LIN_BREAK_BITS) : 5'(data_bits(WORD9_I) + 4'h2);
  always_comb begin
    ts_nxt = ts_r; tph_nxt = tph_r; tbit_nxt = tbit_r; tsh_nxt = tsh_r;
    tkind_nxt = tkind_r; tbrk_nxt = tbrk_r; tmark_nxt = tmark_r; tidle_nxt = tidle_r;
    sarm_nxt = sarm_r; tde_nxt = tde_r; tc_nxt = tc_r;
    out_nxt = out_r;
    f_pop = 1'b0;
    if (STATUS_ACCESS_I) sarm_nxt = 1'b1;
    if (DATA_WR_I && sarm_r) begin
      sarm_nxt = 1'b0; tde_nxt = 1'b0; tc_nxt = 1'b0;
    end
    if (TX_ON_I && !ton_d_r) tidle_nxt = 1'b1;
    if (!TX_ON_I && ts_r == TS_IDLE) begin
      ts_nxt = TS_OFF; out_nxt = 1'b1;
    end
    if (ts_r == TS_OFF && TX_ON_I) begin
      ts_nxt = TS_IDLE; out_nxt = 1'b1;
    end else if (ts_r == TS_IDLE && TX_ON_I) begin
      out_nxt = 1'b1;
      tph_nxt = '0;
      if (tidle_r) begin
        ts_nxt = TS_DATA; tidle_nxt = 1'b0; tkind_nxt = 1'b0; tbrk_nxt = 1'b0;
        // start slot plus data slots here; the stop state adds the last one
        tsh_nxt = '1; tbit_nxt = 4'(data_bits(WORD9_I) + 4'h1);
      end else if (tmark_r) begin
        ts_nxt = TS_STOP; tmark_nxt = 1'b0; tkind_nxt = 1'b0;
      end else if (SEND_BREAK_I) begin
        ts_nxt = TS_DATA; tkind_nxt = 1'b0; tbrk_nxt = 1'b1; tsh_nxt = '0; out_nxt = 1'b0;
        tbit_nxt = brk_len[3:0] == 4'h0 ? 4'hf : brk_len[3:0];
      end else if (f_valid) begin
        f_pop = 1'b1; ts_nxt = TS_START; tsh_nxt = f_data; tkind_nxt = 1'b1;
        out_nxt = 1'b0; tde_nxt = 1'b1; tbit_nxt = data_bits(WORD9_I);
      end else if (DATA_WR_I && sarm_r) begin
        ts_nxt = TS_START; tsh_nxt = wr_word; tkind_nxt = 1'b1;
        out_nxt = 1'b0; tde_nxt = 1'b1; tbit_nxt = data_bits(WORD9_I);
      end
    end else if (tx_tick) begin
      tph_nxt = tph_r + 4'h1;
      if (tph_r == 4'(`OVERSAMPLE - 1)) begin
        case (ts_r)
          TS_START: begin
            ts_nxt = TS_DATA; out_nxt = tsh_r[0];
          end
          TS_DATA: begin
            tbit_nxt = tbit_r - 4'h1;
            if (!tbrk_r || tkind_r) tsh_nxt = {1'b1, tsh_r[8:1]};
            if (tbit_r == 4'h1) begin
              if (tbrk_r) begin
                ts_nxt = TS_IDLE; tc_nxt = 1'b1; tmark_nxt = !SEND_BREAK_I;
                tbrk_nxt = 1'b0; out_nxt = SEND_BREAK_I ? 1'b0 : 1'b1;
              end else begin
                ts_nxt = TS_STOP; out_nxt = 1'b1;
              end
            end else begin
              out_nxt = tbrk_r ? 1'b0 : tsh_r[1];
            end
          end
          TS_STOP: begin
            ts_nxt = TS_IDLE; out_nxt = 1'b1;
            if (tkind_r) tc_nxt = 1'b1;
          end
          default: ts_nxt = TS_IDLE;
        endcase
      end
    end
    if (!TX_ON_I && ts_r == TS_OFF) out_nxt = 1'b1;
    // follows the next state so the drive drops together with the off state
    oe_nxt = TX_ON_I || ts_nxt != TS_OFF;
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ts_r <= TS_OFF; tph_r <= '0; tbit_r <= '0; tsh_r <= '1; tkind_r <= 1'b0;
      tbrk_r <= 1'b0; tmark_r <= 1'b0; tidle_r <= 1'b0; ton_d_r <= 1'b0; sarm_r <= 1'b0;
      tde_r <= `TX_FLAGS_RST; tc_r <= `TX_FLAGS_RST; out_r <= 1'b1; oe_r <= 1'b0;
    end else begin
      ts_r <= ts_nxt; tph_r <= tph_nxt; tbit_r <= tbit_nxt; tsh_r <= tsh_nxt;
      tkind_r <= tkind_nxt; tbrk_r <= tbrk_nxt; tmark_r <= tmark_nxt; tidle_r <= tidle_nxt;
      ton_d_r <= TX_ON_I; sarm_r <= sarm_nxt; tde_r <= tde_nxt; tc_r <= tc_nxt;
      out_r <= out_nxt; oe_r <= oe_nxt;
    end
  end
  // rx side: pin passes two flops before use
  logic rin_m_r, rin_r;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rin_m_r <= 1'b1; rin_r <= 1'b1;
    end else begin
      rin_m_r <= SERIAL_IN_PIN_I; rin_r <= rin_m_r;
    end
  end
  rx_st_e rs_r, rs_nxt;
  logic [3:0] rph_r, rph_nxt, rbit_r, rbit_nxt;
  logic [2:0] smp_r, smp_nxt;
  word_t rsh_r, rsh_nxt, rbuf_r, rbuf_nxt;
  logic rnz_r, rnz_nxt, rf_r, rf_nxt, ro_r, ro_nxt, rn_r, rn_nxt, rfe_r, rfe_nxt;
  logic rarm_r, rarm_nxt, maj, noisy, rdone;
  baud_tick #(.DW(`BAUD_DIV_W)) u_rxb (
    .clk_i(CLK_I), .rstn_i(RSTN_I), .run_i(RX_ON_I), .div_i(RX_DIV_I), .tick_o(rx_tick));
  always_comb begin
    maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
    noisy = !(smp_r == 3'h0 || smp_r == 3'h7);
    rs_nxt = rs_r; rph_nxt = rph_r; rbit_nxt = rbit_r; smp_nxt = smp_r; rsh_nxt = rsh_r;
    rbuf_nxt = rbuf_r; rnz_nxt = rnz_r; rf_nxt = rf_r; ro_nxt = ro_r; rn_nxt = rn_r;
    rfe_nxt = rfe_r; rarm_nxt = rarm_r; rdone = 1'b0;
    if (STATUS_ACCESS_I) rarm_nxt = 1'b1;
    if (DATA_RD_I && rarm_r) begin
      rarm_nxt = 1'b0; rf_nxt = 1'b0; ro_nxt = 1'b0; rn_nxt = 1'b0; rfe_nxt = 1'b0;
    end
    if (!RX_ON_I) begin
      rs_nxt = RS_HUNT;
    end else if (rx_tick) begin
      rph_nxt = rph_r + 4'h1;
      if (rph_r == 4'(`OVS_MID_A) || rph_r == 4'(`OVS_MID_B) || rph_r == 4'(`OVS_MID_C))
        smp_nxt = {smp_r[1:0], rin_r};
      case (rs_r)
        RS_HUNT: begin
          rph_nxt = '0;
          if (!rin_r) begin
            rs_nxt = RS_START; rph_nxt = 4'h1; rnz_nxt = 1'b0; rbit_nxt = '0;
          end
        end
        RS_START: if (rph_r == 4'hf) begin
          if (maj) rs_nxt = RS_HUNT; // false start
          else rs_nxt = RS_DATA;
          rnz_nxt = noisy;
        end
        RS_DATA: if (rph_r == 4'hf) begin
          rsh_nxt = WORD9_I ? {maj, rsh_r[8:1]} : {1'b0, maj, rsh_r[7:1]};
          rnz_nxt = rnz_r | noisy;
          rbit_nxt = rbit_r + 4'h1;
          if (rbit_r == data_bits(WORD9_I) - 4'h1) rs_nxt = RS_STOP;
        end
        // decide one tick after the last sample so all three stop samples are in
        RS_STOP: if (rph_r == 4'(`OVS_MID_C + 1)) begin
          rdone = 1'b1; rs_nxt = RS_HUNT;
        end
        default: rs_nxt = RS_HUNT;
      endcase
      if (rdone) begin
        // a clear in the same cycle frees the buffer, so the new word wins
        if (rf_nxt) begin
          ro_nxt = 1'b1;
        end else begin
          rbuf_nxt = rsh_r; rf_nxt = 1'b1;
          rn_nxt = rnz_r | noisy;
          rfe_nxt = !maj;
        end
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rs_r <= RS_HUNT; rph_r <= '0; rbit_r <= '0; smp_r <= 3'h7; rsh_r <= '0; rbuf_r <= '0;
      rnz_r <= 1'b0; rf_r <= 1'b0; ro_r <= 1'b0; rn_r <= 1'b0; rfe_r <= 1'b0; rarm_r <= 1'b0;
    end else begin
      rs_r <= rs_nxt; rph_r <= rph_nxt; rbit_r <= rbit_nxt; smp_r <= smp_nxt; rsh_r <= rsh_nxt;
      rbuf_r <= rbuf_nxt; rnz_r <= rnz_nxt; rf_r <= rf_nxt; ro_r <= ro_nxt; rn_r <= rn_nxt;
      rfe_r <= rfe_nxt; rarm_r <= rarm_nxt;
    end
  end
  logic irq_r;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) irq_r <= 1'b0;
    else irq_r <= GROUP0_IRQ_UNMASK_I && ((TX_EMPTY_IRQ_EN_I && tde_r)
      || (TX_DONE_IRQ_EN_I && tc_r) || (RX_FULL_IRQ_EN_I && (rf_r || ro_r)));
  end
  assign SERIAL_OUT_O = out_r;
  assign SERIAL_OUT_OE_O = oe_r;
  assign TX_BUFFER_EMPTY_FLAG_O = tde_r;
  assign TX_DONE_FLAG_O = tc_r;
  assign RX_BUFFER_FULL_FLAG_O = rf_r;
  assign OVERRUN_FLAG_O = ro_r;
  assign NOISE_FLAG_O = rn_r;
  assign FRAMING_FLAG_O = rfe_r;
  assign DATA_RDATA_O = rbuf_r[7:0];
  assign RX_NINTH_BIT_O = rbuf_r[8];
  assign IRQ_O = irq_r;
  AST_OE_OFF: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ts_r == TS_OFF && !$past(TX_ON_I)) |-> !SERIAL_OUT_OE_O) else $error("pin driven while off");
  AST_START_LOW: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ts_r == TS_START) |-> !SERIAL_OUT_O) else $error("start bit not low");
  AST_STOP_HIGH: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ts_r == TS_STOP) |-> SERIAL_OUT_O) else $error("stop bit not high");
  AST_TDE_CLR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ($fell(tde_r) |-> $past(DATA_WR_I && sarm_r))) else $error("empty flag cleared wrongly");
  AST_TC_CLR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    ($fell(tc_r) |-> $past(DATA_WR_I && sarm_r))) else $error("done flag cleared wrongly");
  AST_IRQ: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (GROUP0_IRQ_UNMASK_I && TX_EMPTY_IRQ_EN_I && tde_r) |=> IRQ_O) else $error("no irq");
  AST_NF_WITH_RF: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $rose(NOISE_FLAG_O) |-> $rose(RX_BUFFER_FULL_FLAG_O)) else $error("noise flag alone");
  AST_OVR_KEEP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (rf_r && !(DATA_RD_I && rarm_r)) |=> $stable(rbuf_r)) else $error("buffer overwritten");
  AST_RF_CLR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $fell(rf_r) |-> $past(DATA_RD_I && rarm_r)) else $error("full flag cleared wrongly");
  COV_TX: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(tc_r));
  COV_RX: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(rf_r));
  COV_OVR: cover property (@(posedge CLK_I) disable iff (!RSTN_I) $rose(ro_r));
  COV_BRK: cover property (@(posedge CLK_I) disable iff (!RSTN_I) tbrk_r && SEND_BREAK_I);
endmodule

//--- test/serial_peer.sv
`timescale 1ns/1ps
// far-side serial equipment: decodes the transmit line, drives the receive line
module serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i, // clock
  input wire logic line_i, // transmit line as seen on the wire
  input wire logic word9_i, // expect 9-bit words
  output logic rx_line_o, // receive line, idles high
  output logic [8:0] last_word_o, // last decoded word
  output logic last_stop_o, // stop level of last frame
  output int frames_o, // decoded frame count
  output int last_low_o // clocks of the last low run
);
  int low_cnt;
  initial begin
    rx_line_o = 1'b1;
    frames_o = 0;
    last_low_o = 0;
    low_cnt = 0;
  end
  always @(posedge clk_i) begin
    if (line_i === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end else begin
      if (low_cnt != 0) last_low_o <= low_cnt;
      low_cnt <= 0;
    end
  end
  initial begin : decode
    logic [8:0] w;
    int n;
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        n = word9_i ? 9 : 8;
        w = '0;
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
          repeat (BIT_CLKS) @(posedge clk_i);
          w[i] = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        last_word_o = w;
        last_stop_o = line_i;
        frames_o = frames_o + 1;
        while (line_i !== 1'b1) @(posedge clk_i);
      end
    end
  end
  // glitch flips the first data bit for two clocks near its middle only
  task automatic send(input logic [8:0] w, input int n, input logic stop, input bit glitch);
    @(negedge clk_i) rx_line_o = 1'b0;
    repeat (BIT_CLKS) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_line_o = w[i];
      if (glitch && i == 0) begin
        repeat (BIT_CLKS / 2) @(negedge clk_i);
        rx_line_o = ~w[0];
        repeat (2) @(negedge clk_i);
        rx_line_o = w[0];
        repeat (BIT_CLKS / 2 - 2) @(negedge clk_i);
      end else begin
        repeat (BIT_CLKS) @(negedge clk_i);
      end
    end
    rx_line_o = stop;
    repeat (BIT_CLKS) @(negedge clk_i);
    rx_line_o = 1'b1;
    repeat (BIT_CLKS) @(negedge clk_i);
  endtask
endmodule

//--- test/uart_lin_bench.sv
`timescale 1ns/1ps
module uart_lin_bench;
  import uart_lin_pkg::*;
  localparam int BITC = 32;
  logic CLK_I = 1'b0, RSTN_I = 1'b0, TX_ON_I = 1'b0, RX_ON_I = 1'b0, WORD9_I = 1'b0;
  logic LIN_MASTER_I = 1'b0, SEND_BREAK_I = 1'b0, TX_NINTH_BIT_I = 1'b0;
  logic TX_EMPTY_IRQ_EN_I = 1'b0, TX_DONE_IRQ_EN_I = 1'b0, RX_FULL_IRQ_EN_I = 1'b0;
  logic GROUP0_IRQ_UNMASK_I = 1'b0, STATUS_ACCESS_I = 1'b0, DATA_WR_I = 1'b0, DATA_RD_I = 1'b0;
  logic [7:0] DATA_WDATA_I = 8'h00;
  div_t TX_DIV_I = 16'h0002, RX_DIV_I = 16'h0002;
  logic SERIAL_IN_PIN_I, SERIAL_OUT_O, SERIAL_OUT_OE_O, RX_NINTH_BIT_O, IRQ_O;
  logic TX_BUFFER_EMPTY_FLAG_O, TX_DONE_FLAG_O, RX_BUFFER_FULL_FLAG_O;
  logic OVERRUN_FLAG_O, NOISE_FLAG_O, FRAMING_FLAG_O, tx_line, last_stop;
  logic [7:0] DATA_RDATA_O;
  logic [8:0] last_word;
  int frames, last_low, failures = 0, checked = 0;
  always #2.5 CLK_I = ~CLK_I;
  // the transmit line carries a pull-up, so a released pin reads high
  assign tx_line = SERIAL_OUT_OE_O ? SERIAL_OUT_O : 1'b1;
  uart_lin u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .SERIAL_IN_PIN_I(SERIAL_IN_PIN_I),
    .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .TX_ON_I(TX_ON_I),
    .RX_ON_I(RX_ON_I), .WORD9_I(WORD9_I), .LIN_MASTER_I(LIN_MASTER_I),
    .SEND_BREAK_I(SEND_BREAK_I), .TX_NINTH_BIT_I(TX_NINTH_BIT_I), .TX_DIV_I(TX_DIV_I),
    .RX_DIV_I(RX_DIV_I), .TX_EMPTY_IRQ_EN_I(TX_EMPTY_IRQ_EN_I),
    .TX_DONE_IRQ_EN_I(TX_DONE_IRQ_EN_I), .RX_FULL_IRQ_EN_I(RX_FULL_IRQ_EN_I),
    .GROUP0_IRQ_UNMASK_I(GROUP0_IRQ_UNMASK_I), .STATUS_ACCESS_I(STATUS_ACCESS_I),
    .DATA_WR_I(DATA_WR_I), .DATA_WDATA_I(DATA_WDATA_I), .DATA_RD_I(DATA_RD_I),
    .DATA_RDATA_O(DATA_RDATA_O), .RX_NINTH_BIT_O(RX_NINTH_BIT_O),
    .TX_BUFFER_EMPTY_FLAG_O(TX_BUFFER_EMPTY_FLAG_O), .TX_DONE_FLAG_O(TX_DONE_FLAG_O),
    .RX_BUFFER_FULL_FLAG_O(RX_BUFFER_FULL_FLAG_O), .OVERRUN_FLAG_O(OVERRUN_FLAG_O),
    .NOISE_FLAG_O(NOISE_FLAG_O), .FRAMING_FLAG_O(FRAMING_FLAG_O), .IRQ_O(IRQ_O));
  serial_peer #(.BIT_CLKS(BITC)) u_peer (.clk_i(CLK_I), .line_i(tx_line), .word9_i(WORD9_I),
    .rx_line_o(SERIAL_IN_PIN_I), .last_word_o(last_word), .last_stop_o(last_stop),
    .frames_o(frames), .last_low_o(last_low));

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_I);
  endtask
  task automatic tx_write(input logic [7:0] d);
    @(negedge CLK_I) STATUS_ACCESS_I = 1'b1;
    @(negedge CLK_I) STATUS_ACCESS_I = 1'b0;
    DATA_WR_I = 1'b1;
    DATA_WDATA_I = d;
    @(negedge CLK_I) DATA_WR_I = 1'b0;
  endtask
  task automatic rd_clear();
    @(negedge CLK_I) STATUS_ACCESS_I = 1'b1;
    @(negedge CLK_I) STATUS_ACCESS_I = 1'b0;
    DATA_RD_I = 1'b1;
    @(negedge CLK_I) DATA_RD_I = 1'b0;
  endtask
  task automatic wait_frame(input int old);
    int k;
    for (k = 0; k < 2000 && frames == old; k++) cyc(1);
    check("frame arrived", 9'h001, {8'h00, frames != old});
  endtask
  task automatic t_reset();
    check("oe", 9'h000, {8'h00, SERIAL_OUT_OE_O});
    check("flags", 9'h030, {3'b000, TX_BUFFER_EMPTY_FLAG_O, TX_DONE_FLAG_O,
      RX_BUFFER_FULL_FLAG_O, OVERRUN_FLAG_O, NOISE_FLAG_O, FRAMING_FLAG_O});
    TX_EMPTY_IRQ_EN_I = 1'b1;
    GROUP0_IRQ_UNMASK_I = 1'b1;
    cyc(3);
    check("irq empty", 9'h001, {8'h00, IRQ_O});
    GROUP0_IRQ_UNMASK_I = 1'b0;
    cyc(3);
    check("irq masked", 9'h000, {8'h00, IRQ_O});
    TX_EMPTY_IRQ_EN_I = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_enable();
    int lows = 0;
    int f0 = frames;
    TX_ON_I = 1'b1;
    cyc(3);
    check("oe on", 9'h001, {8'h00, SERIAL_OUT_OE_O});
    repeat (11 * BITC) begin
      cyc(1);
      if (SERIAL_OUT_O !== 1'b1) lows++;
    end
    check("idle lows", 9'h000, 9'(lows));
    DATA_WR_I = 1'b1;
    cyc(1);
    DATA_WR_I = 1'b0;
    cyc(3 * BITC);
    check("unarmed write", 9'h00c, {5'h00, TX_BUFFER_EMPTY_FLAG_O, TX_DONE_FLAG_O, 2'b00});
    check("no frame", 9'(f0), 9'(frames));
    $display("test enable done");
  endtask
  task automatic t_byte();
    int f0 = frames;
    TX_DONE_IRQ_EN_I = 1'b1;
    GROUP0_IRQ_UNMASK_I = 1'b1;
    tx_write(8'ha5);
    check("empty set", 9'h001, {8'h00, TX_BUFFER_EMPTY_FLAG_O});
    check("done clear", 9'h000, {8'h00, TX_DONE_FLAG_O});
    wait_frame(f0);
    check("word", 9'h0a5, last_word);
    check("stop", 9'h001, {8'h00, last_stop});
    cyc(BITC + 8);
    check("done set", 9'h001, {8'h00, TX_DONE_FLAG_O});
    check("irq done", 9'h001, {8'h00, IRQ_O});
    TX_DONE_IRQ_EN_I = 1'b0;
    $display("test byte done");
  endtask
  task automatic t_fill();
    int f0 = frames;
    for (int i = 0; i < 6; i++) tx_write(8'h10 + 8'(i));
    check("empty held", 9'h000, {8'h00, TX_BUFFER_EMPTY_FLAG_O});
    for (int i = 0; i < 5; i++) begin
      wait_frame(f0 + i);
      check("queued word", 9'h010 + 9'(i), last_word);
    end
    cyc(12 * BITC);
    check("dropped word", 9'(f0 + 5), 9'(frames));
    $display("test fill done");
  endtask
  task automatic t_word9();
    int f0 = frames;
    WORD9_I = 1'b1;
    TX_NINTH_BIT_I = 1'b1;
    tx_write(8'h3c);
    wait_frame(f0);
    check("word9", 9'h13c, last_word);
    cyc(2 * BITC);
    WORD9_I = 1'b0;
    $display("test word9 done");
  endtask
  task automatic t_lin();
    int k;
    LIN_MASTER_I = 1'b1;
    SEND_BREAK_I = 1'b1;
    for (k = 0; k < 2000 && tx_line !== 1'b0; k++) cyc(1);
    cyc(BITC);
    SEND_BREAK_I = 1'b0;
    // the write clears the done flag and queues a word behind the break
    tx_write(8'h55);
    for (k = 0; k < 2000 && tx_line !== 1'b1; k++) cyc(1);
    cyc(BITC / 2);
    check("line after break", 9'h001, {8'h00, tx_line});
    check("done by break", 9'h001, {8'h00, TX_DONE_FLAG_O});
    checked++;
    if (last_low < 13 * BITC - 16 || last_low > 13 * BITC + 16) begin
      $display("Error break clocks expected %0d seen %0d", 13 * BITC, last_low);
      failures++;
    end
    cyc(12 * BITC);
    check("done after break", 9'h001, {8'h00, TX_DONE_FLAG_O});
    check("word after break", 9'h055, last_word);
    LIN_MASTER_I = 1'b0;
    $display("test lin done");
  endtask
  task automatic t_rx();
    RX_ON_I = 1'b1;
    RX_FULL_IRQ_EN_I = 1'b1;
    cyc(4);
    u_peer.send(9'h05a, 8, 1'b1, 1'b0);
    check("rx data", 9'h05a, {1'b0, DATA_RDATA_O});
    check("rx flags", 9'h008, {5'h00, RX_BUFFER_FULL_FLAG_O, OVERRUN_FLAG_O, NOISE_FLAG_O,
      FRAMING_FLAG_O});
    check("rx irq", 9'h001, {8'h00, IRQ_O});
    u_peer.send(9'h033, 8, 1'b1, 1'b0);
    check("overrun", 9'h001, {8'h00, OVERRUN_FLAG_O});
    check("kept data", 9'h05a, {1'b0, DATA_RDATA_O});
    rd_clear();
    cyc(2);
    check("cleared", 9'h000, {7'h00, RX_BUFFER_FULL_FLAG_O, OVERRUN_FLAG_O});
    u_peer.send(9'h0ab, 8, 1'b1, 1'b1);
    check("noisy data", 9'h0ab, {1'b0, DATA_RDATA_O});
    check("noise", 9'h003, {7'h00, NOISE_FLAG_O, RX_BUFFER_FULL_FLAG_O});
    rd_clear();
    WORD9_I = 1'b1;
    u_peer.send(9'h1c3, 9, 1'b1, 1'b0);
    check("ninth", 9'h1c3, {RX_NINTH_BIT_O, DATA_RDATA_O});
    rd_clear();
    WORD9_I = 1'b0;
    u_peer.send(9'h000, 8, 1'b0, 1'b0);
    check("framing", 9'h003, {7'h00, FRAMING_FLAG_O, RX_BUFFER_FULL_FLAG_O});
    rd_clear();
    $display("test rx done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(3);
    RSTN_I = 1'b1;
    cyc(1);
    t_reset();
    t_enable();
    t_byte();
    t_fill();
    t_word9();
    t_lin();
    t_rx();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge CLK_I);
    failures++;
    complete_run();
  end
endmodule
